// ### bench/rec_excitation_ctrl_assertions.sv
`timescale 1ns/1ps
module rec_excitation_ctrl_chk (
   // Bus
   input wire CLK, input wire RST, input wire [5:0] AVS_ADDRESS,
   input wire AVS_READ, input wire AVS_WRITE, input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE, input wire [31:0] AVS_READDATA,
   input wire AVS_WAITREQUEST, input wire [1:0] AVS_RESPONSE,
   // Steering
   input wire EXTERNAL_RESISTOR_SELECT, input wire WIRE_COUNT_SELECT,
   input wire [3:0] SENSOR_CURRENT_PIN_RATIO, input wire [3:0] POSITIVE_INPUT_RATIO,
   input wire [3:0] NEGATIVE_INPUT_RATIO
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   wire done = (AVS_READ | AVS_WRITE) & !AVS_WAITREQUEST;
   wire [3:0] idx = AVS_ADDRESS[5:2];
   a_reset_steering: assert property ($fell(RST) |-> !EXTERNAL_RESISTOR_SELECT && !WIRE_COUNT_SELECT)
      else $error("steering not at reset state");
   a_reset_levels: assert property ($fell(RST) |-> (SENSOR_CURRENT_PIN_RATIO | POSITIVE_INPUT_RATIO | NEGATIVE_INPUT_RATIO) == 0)
      else $error("current not off after reset");
   a_ratio_legal: assert property (SENSOR_CURRENT_PIN_RATIO inside {0, 1, 4, 5, 6, 9, 10} && POSITIVE_INPUT_RATIO inside {0, 1, 4, 5, 6, 9, 10})
      else $error("illegal ratio");
   a_four_wire_route: assert property (!WIRE_COUNT_SELECT |-> POSITIVE_INPUT_RATIO == 0 && NEGATIVE_INPUT_RATIO == 0)
      else $error("input pins driven in four-wire mode");
   a_three_wire_route: assert property (WIRE_COUNT_SELECT |-> SENSOR_CURRENT_PIN_RATIO == 0)
      else $error("sensor pin driven in three-wire mode");
   a_disable_gates: assert property (done && AVS_WRITE && idx == 1 && AVS_BYTEENABLE[1] && AVS_WRITEDATA[9] |-> ##2 (SENSOR_CURRENT_PIN_RATIO | POSITIVE_INPUT_RATIO | NEGATIVE_INPUT_RATIO) == 0)
      else $error("current still on after disable");
   a_reserved_zero: assert property (done && AVS_READ |-> AVS_READDATA[31:16] == 0 && (idx != 5 || AVS_READDATA[3:0] == 0))
      else $error("reserved bits not zero");
   a_unmapped_error: assert property (done && !(idx inside {1, 5, 8}) |-> AVS_RESPONSE == 2'b11 && (AVS_WRITE || AVS_READDATA == 0))
      else $error("unmapped access not refused");
endmodule
bind rec_excitation_ctrl rec_excitation_ctrl_chk chk (.*);

// ### bench/tb_rtd_excitation_control.sv
`timescale 1ns/1ps
module tb_rtd_excitation_control;
   reg CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0;
   reg [5:0] AVS_ADDRESS = 0;
   reg [31:0] AVS_WRITEDATA = 0;
   reg [3:0] AVS_BYTEENABLE = 0;
   wire [31:0] AVS_READDATA;
   wire AVS_WAITREQUEST, EXTERNAL_RESISTOR_SELECT, WIRE_COUNT_SELECT, CRC_ENABLE;
   wire [1:0] AVS_RESPONSE;
   wire [3:0] SENSOR_CURRENT_PIN_RATIO, POSITIVE_INPUT_RATIO, NEGATIVE_INPUT_RATIO, AMPLIFIER_GAIN;
   integer n_errors = 0, cmp_count = 0, seed = 32'h15B5, k, j;
   reg [15:0] fe = 0, gc = 0, rdat, m;
   reg [18:0] sv;
   localparam [31:0] RT = 32'h0A965410;
   rec_excitation_ctrl dut (.*);
   initial forever #2.5 CLK = ~CLK;
   task chk(input [8*6:1] nm, input [15:0] e, input [15:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task bus(input w, input [3:0] i, input [15:0] d, input [1:0] be);
      begin
         k = $random(seed);
         AVS_ADDRESS <= {i, 2'b00};
         AVS_WRITE <= w;
         AVS_READ <= !w;
         AVS_WRITEDATA <= {k[15:0], d};
         AVS_BYTEENABLE <= {k[17:16], be};
         k = 0;
         // Values read right after the edge are those the slave showed at it
         @(posedge CLK);
         while (AVS_WAITREQUEST !== 1'b0 && k < 50) begin
            k = k + 1;
            @(posedge CLK);
         end
         if (k >= 50) n_errors = n_errors + 1;
         rdat = AVS_READDATA[15:0];
         sv = {WIRE_COUNT_SELECT, EXTERNAL_RESISTOR_SELECT, CRC_ENABLE, AMPLIFIER_GAIN,
               SENSOR_CURRENT_PIN_RATIO, POSITIVE_INPUT_RATIO, NEGATIVE_INPUT_RATIO};
         chk("resp", (i == 1 || i == 5 || i == 8) ? 2'b00 : 2'b11, AVS_RESPONSE);
         AVS_WRITE <= 0;
         AVS_READ <= 0;
         m = {{8{be[1]}}, {8{be[0]}}};
         if (w && i == 1) fe = (fe & ~m | d & m) & 16'h4200;
         if (w && i == 5) gc = (gc & ~m | d & m) & 16'hFFF0;
         @(posedge CLK);
      end
   endtask
   task outs;
      begin
         bus(0, 1, 0, 0);
         chk("fe", fe, rdat);
         bus(0, 5, 0, 0);
         chk("gc", gc, rdat);
         chk("pin", (fe[9] | gc[15]) ? 0 : RT[gc[11:9]*4 +: 4], sv[11:8]);
         chk("pos", (!fe[9] & gc[15]) ? RT[gc[11:9]*4 +: 4] : 0, sv[7:4]);
         chk("neg", (!fe[9] & gc[15]) ? RT[gc[14:12]*4 +: 4] : 0, sv[3:0]);
         chk("misc", {gc[15], gc[8], fe[14], gc[7:4]}, sv[18:12]);
         bus(0, 8, 0, 0);
         chk("stat", {10'h000, !fe[9] && gc[15] && gc[14:12] != 0 && gc[14:12] != 7,
            !fe[9] && gc[11:9] != 0 && gc[11:9] != 7, gc[15], fe[9], 2'b00}, rdat);
      end
   endtask
   task results;
      begin
         if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      #20000;
      n_errors = n_errors + 1;
      results;
   end
   initial begin
      repeat (20) @(posedge CLK);
      RST <= 0;
      @(posedge CLK);
      outs;
      bus(1, 5, 16'h0300, 3); // Excitation level 1 and external resistor in four-wire mode
      outs;
      for (j = 0; j < 8; j = j + 1) begin
         bus(1, 5, 16'h8000 | j << 12 | j << 9, 3); // Equal levels in three-wire mode
         outs;
      end
      bus(1, 1, 16'hFFFF, 3);
      outs;
      for (j = 0; j < 60; j = j + 1) begin
         k = $random(seed);
         bus(1, k[1] ? (k[0] ? 4'h1 : 4'h5) : (k[2] ? 4'h3 : 4'hF), k[31:16], k[4:3]);
         outs;
      end
      bus(0, 4'hF, 0, 3);
      chk("unmap", 0, rdat);
      results;
   end
endmodule

// ### rtl/rec_excitation_ctrl.v
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module rec_excitation_ctrl (
   // Clock and reset
   input wire CLK,
   input wire RST,
   // Avalon-MM slave
   input wire [5:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output wire AVS_WAITREQUEST,
   output reg [1:0] AVS_RESPONSE,
   // Current source steering, amplifier gain and CRC enable
   output reg EXTERNAL_RESISTOR_SELECT,
   output reg [3:0] SENSOR_CURRENT_PIN_RATIO,
   output reg [3:0] POSITIVE_INPUT_RATIO,
   output reg [3:0] NEGATIVE_INPUT_RATIO,
   output reg WIRE_COUNT_SELECT,
   output reg [3:0] AMPLIFIER_GAIN,
   output reg CRC_ENABLE
);
   `include "rec_regs.vh"

   localparam ST_IDLE = 2'b01;
   localparam ST_DONE = 2'b10;

   reg [1:0] state;
   reg [15:0] frontend_control_one;
   reg [15:0] gain_and_sensor_current_control;
   reg [15:0] next_frontend;
   reg [15:0] next_gain;
   reg [15:0] lane_mask;
   reg [15:0] rd_word;
   reg rd_hit;
   wire [3:0] index;
   wire request;
   wire sensor_current_disable;
   wire wire_count_select;
   wire [2:0] excitation_level;
   wire [2:0] compensation_level;
   wire [3:0] exc_ratio;
   wire [3:0] comp_ratio;
   wire exc_active;
   wire comp_active;
   wire [15:0] status_word;

   assign index = AVS_ADDRESS[5:2];
   assign request = AVS_READ | AVS_WRITE;
   // One wait cycle: request accepted in the cycle after it is seen
   assign AVS_WAITREQUEST = request & (state != ST_DONE);

   assign sensor_current_disable = frontend_control_one[`REC_BIT_SENSOR_CURRENT_DISABLE];
   assign wire_count_select = gain_and_sensor_current_control[`REC_BIT_WIRE_COUNT_SELECT];
   assign excitation_level =
      gain_and_sensor_current_control[`REC_EXC_LEVEL_HI:`REC_EXC_LEVEL_LO];
   assign compensation_level =
      gain_and_sensor_current_control[`REC_COMP_LEVEL_HI:`REC_COMP_LEVEL_LO];

   // Function enabled unless disabled by software
   rec_level_decode u_exc (
      .level(excitation_level),
      .enable(!sensor_current_disable),
      .ratio(exc_ratio),
      .active(exc_active)
   );

   // Compensation source exists only in 3/2-wire mode
   rec_level_decode u_comp (
      .level(compensation_level),
      .enable(!sensor_current_disable && wire_count_select),
      .ratio(comp_ratio),
      .active(comp_active)
   );

   // Live drive state, read-only, so software can see what actually reaches the pins
   assign status_word = {8'h00, 2'b00, comp_active, exc_active,
      wire_count_select, sensor_current_disable, 2'b00};

   always @* begin
      lane_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
      // Reserved bits never stored
      next_frontend = (frontend_control_one & ~lane_mask)
         | (AVS_WRITEDATA[15:0] & lane_mask & `REC_MASK_FRONTEND_CONTROL_ONE);
      next_gain = (gain_and_sensor_current_control & ~lane_mask)
         | (AVS_WRITEDATA[15:0] & lane_mask & `REC_MASK_GAIN_CURRENT_CONTROL);
      rd_word = 16'h0000;
      rd_hit = 1'b1;
      case (index)
         `REC_IDX_FRONTEND_CONTROL_ONE: rd_word = frontend_control_one;
         `REC_IDX_GAIN_CURRENT_CONTROL: rd_word = gain_and_sensor_current_control;
         `REC_IDX_STATUS: rd_word = status_word;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge CLK) begin
      if (RST) begin
         state <= ST_IDLE;
         // Internal resistor, 4-wire, current on, levels zero
         frontend_control_one <= `REC_RST_FRONTEND_CONTROL_ONE;
         gain_and_sensor_current_control <= `REC_RST_GAIN_CURRENT_CONTROL;
         AVS_READDATA <= 32'h00000000;
         AVS_RESPONSE <= 2'b00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (request) begin
                  state <= ST_DONE;
                  // Reserved bits read zero
                  AVS_READDATA <= {16'h0000, rd_word};
                  AVS_RESPONSE <= rd_hit ? 2'b00 : 2'b11;
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
               if (AVS_WRITE) begin
                  // Written fields retained
                  if (index == `REC_IDX_FRONTEND_CONTROL_ONE) begin
                     frontend_control_one <= next_frontend;
                  end
                  if (index == `REC_IDX_GAIN_CURRENT_CONTROL) begin
                     gain_and_sensor_current_control <= next_gain;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Registered steering, gain and CRC enable outputs
   always @(posedge CLK) begin
      if (RST) begin
         EXTERNAL_RESISTOR_SELECT <= 1'b0;
         SENSOR_CURRENT_PIN_RATIO <= 4'h0;
         POSITIVE_INPUT_RATIO <= 4'h0;
         NEGATIVE_INPUT_RATIO <= 4'h0;
         WIRE_COUNT_SELECT <= 1'b0;
         AMPLIFIER_GAIN <= 4'h0;
         CRC_ENABLE <= 1'b0;
      end else begin
         // Reference resistor choice
         EXTERNAL_RESISTOR_SELECT <=
            gain_and_sensor_current_control[`REC_BIT_EXTERNAL_RESISTOR_SELECT];
         WIRE_COUNT_SELECT <= wire_count_select;
         AMPLIFIER_GAIN <= gain_and_sensor_current_control[`REC_GAIN_HI:`REC_GAIN_LO];
         CRC_ENABLE <= frontend_control_one[`REC_BIT_CRC_ENABLE];
         // Ratio times 100 uA reference per source
         if (wire_count_select) begin
            // 3/2-wire: excitation on AIN+, compensation on AIN
            SENSOR_CURRENT_PIN_RATIO <= 4'h0;
            POSITIVE_INPUT_RATIO <= exc_ratio;
            NEGATIVE_INPUT_RATIO <= comp_ratio;
         end else begin
            // 4-wire: excitation only, on the sensor current pin
            SENSOR_CURRENT_PIN_RATIO <= exc_ratio;
            POSITIVE_INPUT_RATIO <= 4'h0;
            NEGATIVE_INPUT_RATIO <= 4'h0;
         end
      end
   end
endmodule

// ### rtl/rec_level_decode.v
`timescale 1ns/1ps
module rec_level_decode (
   // Level code in
   input wire [2:0] level,
   input wire enable,
   // Source drive out
   output reg [3:0] ratio,
   output wire active
);
   `include "rec_regs.vh"

   // Codes 7 and up are treated as off so an illegal write never drives current
   always @* begin
      case (level)
         3'h1: ratio = 4'h1;
         3'h2: ratio = 4'h4;
         3'h3: ratio = 4'h5;
         3'h4: ratio = 4'h6;
         3'h5: ratio = 4'h9;
         3'h6: ratio = 4'hA;
         default: ratio = 4'h0;
      endcase
      if (!enable) begin
         ratio = 4'h0;
      end
   end

   assign active = (ratio != 4'h0);
endmodule

// ### rtl/rec_regs.vh
`ifndef REC_REGS_VH
`define REC_REGS_VH

// Register indices (word offsets); byte address is four times the index
`define REC_IDX_FRONTEND_CONTROL_ONE 4'h1
`define REC_IDX_GAIN_CURRENT_CONTROL 4'h5
`define REC_IDX_STATUS 4'h8

// frontend_control_one fields
`define REC_BIT_CRC_ENABLE 14
`define REC_BIT_SENSOR_CURRENT_DISABLE 9
`define REC_MASK_FRONTEND_CONTROL_ONE 16'h4200
`define REC_RST_FRONTEND_CONTROL_ONE 16'h0000

// gain_and_sensor_current_control fields
`define REC_BIT_WIRE_COUNT_SELECT 15
`define REC_COMP_LEVEL_HI 14
`define REC_COMP_LEVEL_LO 12
`define REC_EXC_LEVEL_HI 11
`define REC_EXC_LEVEL_LO 9
`define REC_BIT_EXTERNAL_RESISTOR_SELECT 8
`define REC_GAIN_HI 7
`define REC_GAIN_LO 4
`define REC_MASK_GAIN_CURRENT_CONTROL 16'hFFF0
`define REC_RST_GAIN_CURRENT_CONTROL 16'h0000

// Level codes: 0 off, 1..6 select ratios 1,4,5,6,9,10 of the 100 uA reference
`define REC_LEVEL_OFF 3'h0
`define REC_LEVEL_MAX 3'h6
`define REC_REF_CURRENT_UA 100

`endif
